// ==== ctd_pkg.sv ====
/*
 ctd_pkg: constants for the carrier timer demodulator.
 assumes: single 100 MHz clock domain, no register bus.
*/
package ctd_pkg;
   localparam int unsigned CTD_W = 8;
   localparam logic [7:0] CTD_ALL_ONES = 8'hFF;
   localparam logic [7:0] CTD_ZERO     = 8'h00;
   localparam logic [7:0] CTD_ONE      = 8'h01;
   // glitch filter field
   localparam logic [1:0] CTD_FLT_NONE = 2'h0;
   localparam logic [1:0] CTD_FLT_4    = 2'h1;
   localparam logic [1:0] CTD_FLT_8    = 2'h2;
   localparam int unsigned CTD_FLT_4_CYC = 4;
   localparam int unsigned CTD_FLT_8_CYC = 8;
   // edges are ignored this long after reset while sync and filter settle
   localparam int unsigned CTD_SETTLE_CYC = 12;
   // edge select field
   localparam logic [1:0] CTD_EDGE_FALL = 2'h0;
   localparam logic [1:0] CTD_EDGE_RISE = 2'h1;
   localparam logic [1:0] CTD_EDGE_BOTH = 2'h2;
   // combining function field
   localparam logic [1:0] CTD_LOG_AND  = 2'h0;
   localparam logic [1:0] CTD_LOG_OR   = 2'h1;
   localparam logic [1:0] CTD_LOG_NOR  = 2'h2;
   localparam logic [1:0] CTD_LOG_NAND = 2'h3;
   typedef enum logic [3:0] {
      CTD_IDLE  = 4'h1,
      CTD_FIRST = 4'h2,
      CTD_RUN   = 4'h4,
      CTD_DONE  = 4'h8
   } ctd_state_t;
endpackage : ctd_pkg

// ==== ctd_glitch_filter.sv ====
/*
 ctd_glitch_filter: synchronises the demodulator pin and rejects short pulses.
 assumes: pin is asynchronous; mode field is static while in use.
*/
`timescale 1ns/1ps
`default_nettype none
module ctd_glitch_filter
   import ctd_pkg::*;
(
   input  wire logic       clk,
   input  wire logic       rst,
   input  wire logic       pin,
   input  wire logic [1:0] mode,
   output logic            filtered
);
   logic       sync1;
   logic       sync2;
   logic [3:0] run_cnt;
   logic [3:0] next_run_cnt;
   logic       next_filtered;
   logic [3:0] need;

   always_comb begin
      need = 4'(CTD_FLT_8_CYC);
      if (mode == CTD_FLT_4) begin
         need = 4'(CTD_FLT_4_CYC);
      end
      next_run_cnt = run_cnt;
      next_filtered = filtered;
      if (mode == CTD_FLT_NONE) begin
         next_filtered = sync2;
         next_run_cnt = 4'h0;
      end else if (sync2 == filtered) begin
         next_run_cnt = 4'h0;
      end else if (run_cnt + 4'h1 >= need) begin
         next_filtered = sync2;
         next_run_cnt = 4'h0;
      end else begin
         next_run_cnt = run_cnt + 4'h1;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sync1    <= 1'b0;
         sync2    <= 1'b0;
         run_cnt  <= 4'h0;
         filtered <= 1'b0;
      end else begin
         sync1    <= pin;
         sync2    <= sync1;
         run_cnt  <= next_run_cnt;
         filtered <= next_filtered;
      end
   end
endmodule : ctd_glitch_filter
`default_nettype wire

// ==== ctd_edge_detect.sv ====
/*
 ctd_edge_detect: one-cycle pulses on rising and falling edges of a clean level.
 assumes: input already synchronous to clk.
*/
`timescale 1ns/1ps
`default_nettype none
module ctd_edge_detect
   import ctd_pkg::*;
(
   input  wire logic clk,
   input  wire logic rst,
   input  wire logic level,
   output logic      pos_edge,
   output logic      neg_edge
);
   logic prev;
   logic next_prev;

   always_comb begin
      next_prev = level;
      pos_edge  = level & ~prev;
      neg_edge  = ~level & prev;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         prev <= 1'b0;
      end else begin
         prev <= next_prev;
      end
   end
endmodule : ctd_edge_detect
`default_nettype wire

// ==== ctd_timer.sv ====
/*
 ctd_timer: 8-bit carrier timer / demodulator with ping-pong and output routing.
 assumes: control bits are plain ports; the 16-bit timer lives outside and
 reports its output and terminal count; count_tick is a synchronous strobe.
*/
`timescale 1ns/1ps
`default_nettype none
module ctd_timer
   import ctd_pkg::*;
#(
   parameter int unsigned WIDTH = CTD_W
) (
   input  wire logic             clk,
   input  wire logic             rst,
   input  wire logic             count_tick,
   input  wire logic             demod_input_pin_a,
   input  wire logic             demod_input_pin_b,
   input  wire logic             port_latch_first,
   input  wire logic             port_latch_second,
   input  wire logic             port_latch_combined,
   input  wire logic             enable_set,
   input  wire logic             enable_stop,
   input  wire logic             demod_mode,
   input  wire logic             single_pass,
   input  wire logic             timeout_irq_en,
   input  wire logic             capture_irq_en,
   input  wire logic             route_first,
   input  wire logic             route_second,
   input  wire logic             route_combined,
   input  wire logic             demod_pin_sel,
   input  wire logic [1:0]       logic_func,
   input  wire logic [1:0]       edge_sel,
   input  wire logic [1:0]       filter_sel,
   input  wire logic             initial_value,
   input  wire logic             ping_pong,
   input  wire logic             timer16_output,
   input  wire logic             timer16_terminal,
   input  wire logic [WIDTH-1:0] low_reload_register,
   input  wire logic [WIDTH-1:0] high_reload_register,
   input  wire logic             timeout_clear,
   input  wire logic             rise_clear,
   input  wire logic             fall_clear,
   output logic                  eight_bit_timer_enabled,
   output logic                  timer16_start,
   output logic [WIDTH-1:0]      count,
   output logic [WIDTH-1:0]      high_capture_register,
   output logic [WIDTH-1:0]      low_capture_register,
   output logic                  timeout_status,
   output logic                  rise_status,
   output logic                  fall_status,
   output logic                  timeout_irq,
   output logic                  capture_irq,
   output logic                  timer8_output,
   output logic                  first_timer_output_pin,
   output logic                  second_timer_output_pin,
   output logic                  combined_output_pin
);
   logic             demod_pin;
   logic             clean;
   logic             pos_edge;
   logic             neg_edge;
   logic             sel_pos;
   logic             sel_neg;
   ctd_state_t       state;
   ctd_state_t       next_state;
   logic [WIDTH-1:0] next_count;
   logic [WIDTH-1:0] next_hi_cap;
   logic [WIDTH-1:0] next_lo_cap;
   logic             next_out;
   logic             next_to;
   logic             next_rise;
   logic             next_fall;
   logic             next_to_irq;
   logic             next_cap_irq;
   logic             next_t16_start;
   logic             combo;
   logic             next_first_pin;
   logic             next_second_pin;
   logic             next_combined_pin;
   logic             at_zero;
   logic [WIDTH-1:0] ones;
   logic [WIDTH-1:0] one;
   logic             next_enabled;
   logic             settled;
   logic [3:0]       settle;
   logic [3:0]       next_settle;

   assign demod_pin = demod_pin_sel ? demod_input_pin_b : demod_input_pin_a;
   assign ones = WIDTH'(CTD_ALL_ONES);
   assign one  = WIDTH'(CTD_ONE);
   assign at_zero = (count == WIDTH'(CTD_ZERO));

   ctd_glitch_filter u_filter (
      .clk      (clk),
      .rst      (rst),
      .pin      (demod_pin),
      .mode     (filter_sel),
      .filtered (clean)
   );

   ctd_edge_detect u_edge (
      .clk      (clk),
      .rst      (rst),
      .level    (clean),
      .pos_edge (pos_edge),
      .neg_edge (neg_edge)
   );

   always_comb begin
      sel_pos = settled & pos_edge & ((edge_sel == CTD_EDGE_RISE) | (edge_sel == CTD_EDGE_BOTH));
      sel_neg = settled & neg_edge & ((edge_sel == CTD_EDGE_FALL) | (edge_sel == CTD_EDGE_BOTH));
   end

   // sync chain leaves reset low, so a high idle pin would look like an edge
   always_comb begin
      settled     = (settle == 4'(CTD_SETTLE_CYC));
      next_settle = settled ? settle : settle + 4'h1;
   end

   always_comb begin
      next_state     = state;
      next_count     = count;
      next_hi_cap    = high_capture_register;
      next_lo_cap    = low_capture_register;
      next_out       = timer8_output;
      next_to_irq    = 1'b0;
      next_cap_irq   = 1'b0;
      next_t16_start = 1'b0;
      // flags: clear first so a same-cycle event wins
      next_to   = timeout_status & ~timeout_clear;
      next_rise = rise_status & ~rise_clear;
      next_fall = fall_status & ~fall_clear;
      case (state)
         CTD_IDLE: begin
            next_out = ~initial_value;
            if (enable_set || (ping_pong && timer16_terminal)) begin
               next_out = initial_value;
               next_count = initial_value ? high_reload_register : low_reload_register;
               next_state = (single_pass || demod_mode) ? CTD_RUN : CTD_FIRST;
               if (demod_mode) begin
                  next_count = ones;
               end
            end
         end
         CTD_FIRST, CTD_RUN: begin
            if (enable_stop) begin
               next_state = CTD_IDLE;
            end else if (demod_mode && (sel_pos || sel_neg)) begin
               if (sel_neg) begin
                  next_hi_cap = count;
                  next_fall = 1'b1;
               end else begin
                  next_lo_cap = count;
                  next_rise = 1'b1;
               end
               next_cap_irq = capture_irq_en;
               next_count = ones;
            end else if (count_tick) begin
               if (demod_mode) begin
                  // zero shows one tick, then resumes from FF
                  if (at_zero) begin
                     next_count = ones;
                  end else begin
                     next_count = count - one;
                  end
                  if (count == one) begin
                     next_to = 1'b1;
                     next_to_irq = timeout_irq_en;
                  end
               end else if (count == one) begin
                  next_out = ~timer8_output;
                  next_count = WIDTH'(CTD_ZERO);
                  if (single_pass || ping_pong) begin
                     next_to = 1'b1;
                     next_to_irq = timeout_irq_en & single_pass;
                     next_state = CTD_DONE;
                     if (ping_pong) begin
                        next_state = CTD_IDLE;
                        next_t16_start = 1'b1;
                     end
                  end else begin
                     // reload by the new output level
                     next_count = timer8_output ? low_reload_register : high_reload_register;
                     if (state == CTD_RUN) begin
                        next_to = 1'b1;
                        next_to_irq = timeout_irq_en;
                     end
                     next_state = CTD_RUN;
                  end
               end else begin
                  // count 0 wraps to FF, FE, ... (no stop)
                  next_count = count - one;
               end
            end
         end
         CTD_DONE: begin
            if (enable_stop) begin
               next_state = CTD_IDLE;
            end else if (enable_set) begin
               next_state = CTD_IDLE;
            end
         end
         default: begin
            next_state = CTD_IDLE;
         end
      endcase
      next_enabled = (next_state != CTD_IDLE);
   end

   always_comb begin
      case (logic_func)
         // next level, so the combined pin moves with the first pin
         CTD_LOG_AND:  combo = next_out & timer16_output;
         CTD_LOG_OR:   combo = next_out | timer16_output;
         CTD_LOG_NOR:  combo = ~(next_out | timer16_output);
         default:      combo = ~(next_out & timer16_output);
      endcase
      next_first_pin    = route_first ? next_out : port_latch_first;
      next_second_pin   = route_second ? timer16_output : port_latch_second;
      next_combined_pin = route_combined ? combo : port_latch_combined;
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state                   <= CTD_IDLE;
         eight_bit_timer_enabled <= 1'b0;
         settle                  <= 4'h0;
         count                   <= WIDTH'(CTD_ZERO);
         high_capture_register   <= WIDTH'(CTD_ZERO);
         low_capture_register    <= WIDTH'(CTD_ZERO);
         timer8_output           <= 1'b1;
         timeout_status          <= 1'b0;
         rise_status             <= 1'b0;
         fall_status             <= 1'b0;
         timeout_irq             <= 1'b0;
         capture_irq             <= 1'b0;
         timer16_start           <= 1'b0;
         first_timer_output_pin  <= 1'b0;
         second_timer_output_pin <= 1'b0;
         combined_output_pin     <= 1'b0;
      end else begin
         state                   <= next_state;
         eight_bit_timer_enabled <= next_enabled;
         settle                  <= next_settle;
         count                   <= next_count;
         high_capture_register   <= next_hi_cap;
         low_capture_register    <= next_lo_cap;
         timer8_output           <= next_out;
         timeout_status          <= next_to;
         rise_status             <= next_rise;
         fall_status             <= next_fall;
         timeout_irq             <= next_to_irq;
         capture_irq             <= next_cap_irq;
         timer16_start           <= next_t16_start;
         first_timer_output_pin  <= next_first_pin;
         second_timer_output_pin <= next_second_pin;
         combined_output_pin     <= next_combined_pin;
      end
   end

   sequence s_enable_idle;
      state == CTD_IDLE && enable_set && !demod_mode;
   endsequence

   chk_idle_output_inverse: assert property (@(posedge clk) disable iff (rst)
      (state == CTD_IDLE && !enable_set && !(ping_pong && timer16_terminal)) |=> timer8_output == !$past(initial_value))
      else $error("idle output not inverse of initial value");

   chk_enable_load: assert property (@(posedge clk) disable iff (rst)
      s_enable_idle |=> (timer8_output == $past(initial_value)) &&
      (count == ($past(initial_value) ? $past(high_reload_register) : $past(low_reload_register))))
      else $error("enable did not load reload value");

   chk_single_stop: assert property (@(posedge clk) disable iff (rst)
      (state == CTD_RUN && single_pass && !demod_mode && !ping_pong && !enable_stop && count_tick && count == one)
      |=> state == CTD_DONE && timeout_status && timer8_output != $past(timer8_output) ##1 state == CTD_DONE || $past(enable_stop) || $past(enable_set))
      else $error("single pass did not stop with timeout");

   chk_first_no_flag: assert property (@(posedge clk) disable iff (rst)
      (state == CTD_FIRST && !single_pass && !ping_pong && !demod_mode && !enable_stop && count_tick && count == one)
      |=> !timeout_irq && state == CTD_RUN)
      else $error("first terminal count raised interrupt");

   chk_modn_reload: assert property (@(posedge clk) disable iff (rst)
      (state == CTD_RUN && !single_pass && !ping_pong && !demod_mode && !enable_stop && count_tick && count == one)
      |=> count == (timer8_output ? $past(high_reload_register) : $past(low_reload_register)))
      else $error("modulo-N reload from wrong register");

   chk_capture_neg: assert property (@(posedge clk) disable iff (rst)
      (state != CTD_IDLE && state != CTD_DONE && demod_mode && !enable_stop && sel_neg)
      |=> high_capture_register == $past(count) && fall_status && count == ones)
      else $error("negative edge capture wrong");

   chk_demod_wrap: assert property (@(posedge clk) disable iff (rst)
      (state == CTD_RUN && demod_mode && !enable_stop && !sel_pos && !sel_neg && count_tick && at_zero)
      |=> count == ones)
      else $error("demod zero did not resume from FF");

   chk_flag_sticky: assert property (@(posedge clk) disable iff (rst)
      (timeout_status && !timeout_clear) |=> timeout_status)
      else $error("timeout status lost without clear");

   chk_combo_route: assert property (@(posedge clk) disable iff (rst)
      (route_combined && logic_func == CTD_LOG_AND)
      |=> combined_output_pin == (timer8_output & $past(timer16_output)))
      else $error("combined pin wrong");

   sequence s_pp_terminal;
      (state == CTD_FIRST || state == CTD_RUN) && ping_pong && !demod_mode && !enable_stop && count_tick && count == one;
   endsequence

   chk_capture_pos: assert property (@(posedge clk) disable iff (rst)
      (state != CTD_IDLE && state != CTD_DONE && demod_mode && !enable_stop && sel_pos && !sel_neg)
      |=> low_capture_register == $past(count) && rise_status && count == ones)
      else $error("positive edge capture wrong");

   chk_pp_handover: assert property (@(posedge clk) disable iff (rst)
      s_pp_terminal |=> state == CTD_IDLE && timer16_start && timeout_status && !eight_bit_timer_enabled)
      else $error("ping-pong handover missing");

   chk_stop_disable: assert property (@(posedge clk) disable iff (rst)
      (state != CTD_IDLE && enable_stop) |=> !eight_bit_timer_enabled ##1
      (eight_bit_timer_enabled || timer8_output == !$past(initial_value)))
      else $error("stop did not disable timer");
endmodule : ctd_timer
`default_nettype wire

// ==== ctd_pin_model.sv ====
/*
 ctd_pin_model: far-side pulse source for the two demodulator pins.
 assumes: clocked by the bench clock; selected pin idles high.
*/
`timescale 1ns/1ps
`default_nettype none
module ctd_pin_model (
   input  wire logic       clk,
   input  wire logic       go,
   input  wire logic       pick_b,
   input  wire logic [7:0] width,
   output logic            pin_a,
   output logic            pin_b
);
   logic [7:0] left = 8'h00;
   logic       wig  = 1'b0;
   // unselected pin wiggles, so a wrong pin select shows as edges
   always @(posedge clk) begin
      wig <= !wig;
      if (go) left <= width;
      else if (left != 8'h00) left <= left - 8'h01;
   end
   assign pin_a = pick_b ? wig : (left == 8'h00);
   assign pin_b = pick_b ? (left == 8'h00) : wig;
endmodule : ctd_pin_model
`default_nettype wire

// ==== tb_carrier_timer_demodulator.sv ====
/*
 tb_carrier_timer_demodulator: self-checking bench with a cycle model.
 assumes: ctd_pkg, ctd_timer and ctd_pin_model compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_carrier_timer_demodulator
   import ctd_pkg::*;
;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic tick, pa, pb, lf, ls, lc, es, est, dm, sp, tie, cie, rf, rs, rc, psel, iv, pp, t16o, t16t;
   logic toc, ric, fac, en8, st16, tos, ris, fas, toi, cpi, t8o, p1, p2, p3, go, kick, poke, rld, chk;
   logic [1:0] lfn, esel, fsel;
   logic [7:0] lo, hi, cnt, hcap, lcap, wid, mcnt, prev;
   logic [31:0] r = 32'h00000049;
   logic mout, mto, mirq, mst16, first, m1, m2, m3, cmb;
   int st, failures, checks, ncap;
   int te[6] = '{0, 1, 2, 2, 2, 0};
   int tf[6] = '{0, 0, 1, 1, 2, 2};
   int tw[6] = '{12, 12, 12, 2, 6, 12};
   int tn[6] = '{1, 1, 2, 0, 0, 1};
   int tsp[5] = '{0, 0, 1, 0, 0};
   int tiv[5] = '{0, 1, 0, 1, 1};
   int tpp[5] = '{0, 0, 0, 0, 1};
   int tz[5] = '{0, 0, 0, 1, 0};

   always #5 clk = !clk;

   ctd_timer #(.WIDTH(8)) u_ctd_timer (
      .clk(clk), .rst(rst), .count_tick(tick), .demod_input_pin_a(pa), .demod_input_pin_b(pb),
      .port_latch_first(lf), .port_latch_second(ls), .port_latch_combined(lc), .enable_set(es),
      .enable_stop(est), .demod_mode(dm), .single_pass(sp), .timeout_irq_en(tie),
      .capture_irq_en(cie), .route_first(rf), .route_second(rs), .route_combined(rc),
      .demod_pin_sel(psel), .logic_func(lfn), .edge_sel(esel), .filter_sel(fsel), .initial_value(iv),
      .ping_pong(pp), .timer16_output(t16o), .timer16_terminal(t16t), .low_reload_register(lo),
      .high_reload_register(hi), .timeout_clear(toc), .rise_clear(ric), .fall_clear(fac),
      .eight_bit_timer_enabled(en8), .timer16_start(st16), .count(cnt), .high_capture_register(hcap),
      .low_capture_register(lcap), .timeout_status(tos), .rise_status(ris), .fall_status(fas),
      .timeout_irq(toi), .capture_irq(cpi), .timer8_output(t8o), .first_timer_output_pin(p1),
      .second_timer_output_pin(p2), .combined_output_pin(p3));

   ctd_pin_model u_ctd_pin_model (.clk(clk), .go(go), .pick_b(psel), .width(wid), .pin_a(pa), .pin_b(pb));

   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs

   task automatic c1(input logic g, input logic e);
      checks++;
      if (g !== e) begin
         failures++;
         $display("mismatch %0t bit got %b exp %b", $time, g, e);
      end
   endtask : c1

   task automatic c8(input logic [7:0] g, input logic [7:0] e);
      checks++;
      if (g !== e) begin
         failures++;
         $display("mismatch %0t byte got %h exp %h", $time, g, e);
      end
   endtask : c8

   task automatic results();
      if (failures == 0 && checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : results

   // random stimulus; reloads only move well before a reload
   always @(posedge clk) begin
      r = xs(r);
      {lf, ls, lc, rf, rs, rc, t16o, tie} <= r[7:0];
      lfn <= r[9:8];
      tick <= dm | (r[11:10] != 2'h0);
      t16t <= pp & r[12] & r[13];
      toc <= !dm & (r[16:14] == 3'h0);
      es <= kick | (poke & (r[20:17] == 4'h0));
      if (rld && r[24:21] == 4'h0 && mcnt > 8'h03) lo <= {5'h00, r[27:25]} + 8'h02;
      if (rld && r[31:28] == 4'h0 && mcnt > 8'h03) hi <= {5'h00, r[27:25]} + 8'h03;
   end

   // transmit reference model
   always @(posedge clk or posedge rst) begin
      mirq = 1'b0;
      mst16 = 1'b0;
      if (rst) begin
         st = 0;
         mcnt = 8'h00;
         mout = 1'b1;
         mto = 1'b0;
         {m1, m2, m3} = 3'h0;
      end else begin
         if (toc) mto = 1'b0;
         if (st == 0) begin
            mout = !iv;
            if (es || (pp && t16t)) begin
               st = 1;
               first = 1'b1;
               mout = iv;
               mcnt = iv ? hi : lo;
            end
         end else if (est || (st == 2 && es)) begin
            // stop, or a fresh enable after a single pass, disables the timer
            st = 0;
         end else if (st == 1 && tick) begin
            if (mcnt == 8'h01) begin
               mout = !mout;
               if (sp || pp || !first) mto = 1'b1;
               mirq = tie && !pp && (sp || !first);
               if (pp) begin
                  st = 0;
                  mst16 = 1'b1;
               end else if (sp) begin
                  st = 2;
                  mcnt = 8'h00;
               end else mcnt = mout ? hi : lo;
               first = 1'b0;
            end else mcnt = mcnt - 8'h01;
         end
         case (lfn)
            CTD_LOG_AND: cmb = mout & t16o;
            CTD_LOG_OR: cmb = mout | t16o;
            CTD_LOG_NOR: cmb = !(mout | t16o);
            default: cmb = !(mout & t16o);
         endcase
         m1 = rf ? mout : lf;
         m2 = rs ? t16o : ls;
         m3 = rc ? cmb : lc;
      end
   end

   always @(negedge clk) begin
      if (!rst && chk) begin
         c1(en8, st != 0);
         c1(st16, mst16);
         c1(tos, mto);
         if (!pp) begin
            c1(t8o, mout);
            c1(toi, mirq);
            c8(cnt, mcnt);
            c1(p1, m1);
            c1(p2, m2);
            c1(p3, m3);
         end
      end
      if (!rst && dm) begin
         if (cpi) begin
            ncap++;
            c8(cnt, 8'hFF);
            if (esel == CTD_EDGE_FALL) c8(hcap, prev);
            if (esel == CTD_EDGE_RISE) c8(lcap, prev);
         end
         prev = cnt;
      end
   end

   task automatic enable_pulse();
      @(negedge clk) kick = 1'b1;
      @(negedge clk) kick = 1'b0;
   endtask : enable_pulse

   initial begin
      {tick, lf, ls, lc, es, est, dm, sp, tie, rf, rs, rc, psel, iv, pp, t16o, t16t} = 17'h00000;
      {toc, ric, fac, go, kick, poke, rld, chk} = 8'h00;
      {lfn, esel, fsel} = 6'h00;
      {lo, hi, wid} = {8'h05, 8'h03, 8'h00};
      cie = 1'b1;
      dm = 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      enable_pulse();
      repeat (240) @(posedge clk);
      @(negedge clk);
      c1(tos, 1'b0);
      repeat (30) @(posedge clk);
      @(negedge clk);
      c1(tos, 1'b1);
      for (int i = 0; i < 6; i++) begin
         @(posedge clk);
         esel <= te[i][1:0];
         fsel <= tf[i][1:0];
         wid <= tw[i][7:0];
         psel <= i[0];
         repeat (20) @(posedge clk);
         {ric, fac} <= 2'h3;
         @(posedge clk);
         {ric, fac} <= 2'h0;
         ncap = 0;
         go <= 1'b1;
         @(posedge clk);
         go <= 1'b0;
         repeat (40) @(posedge clk);
         @(negedge clk);
         c8(ncap[7:0], tn[i][7:0]);
         c1(fas, tn[i] > 0 && te[i] != 1);
         c1(ris, tn[i] > 0 && te[i] != 0);
      end
      for (int i = 0; i < 5; i++) begin
         @(posedge clk);
         rst <= 1'b1;
         dm <= 1'b0;
         sp <= tsp[i][0];
         iv <= tiv[i][0];
         pp <= tpp[i][0];
         lo <= tz[i] ? 8'h00 : 8'h04;
         hi <= tz[i] ? 8'h00 : 8'h06;
         rld <= !tz[i];
         poke <= !tsp[i] && !tpp[i];
         repeat (2) @(posedge clk);
         rst <= 1'b0;
         chk = 1'b1;
         repeat (3) @(posedge clk);
         enable_pulse();
         repeat (tz[i] ? 900 : 300) @(posedge clk);
         est <= 1'b1;
         @(posedge clk);
         est <= 1'b0;
         repeat (4) @(posedge clk);
      end
      results();
   end

   initial begin
      #200us;
      failures++;
      results();
   end
endmodule : tb_carrier_timer_demodulator
`default_nettype wire
